// >>> shared/cdp_defines.svh
// Offsets, field positions and reset values of the core datapath
`ifndef CDP_DEFINES_SVH
`define CDP_DEFINES_SVH
`define CDP_IO_STACK_LOW 6'h3D
`define CDP_IO_STACK_HIGH 6'h3E
`define CDP_IO_SREG 6'h3F
`define CDP_IO_BASE 16'h0020
`define CDP_IO_LAST 16'h005F
`define CDP_VEC_SHIFT 1
`define CDP_SREG_RESET 8'h00
`define CDP_F_C 0
`define CDP_F_Z 1
`define CDP_F_N 2
`define CDP_F_V 3
`define CDP_F_S 4
`define CDP_F_H 5
`define CDP_F_I 7
`endif

// >>> shared/cdp_pkg.sv
// Types of the core datapath
package cdp_pkg;
   typedef enum logic [8:0] {
      ST_EXEC = 9'h001, ST_IMM = 9'h002, ST_LOAD = 9'h004,
      ST_PUSH1 = 9'h008, ST_PUSH2 = 9'h010, ST_POP1 = 9'h020,
      ST_POP2 = 9'h040, ST_POP3 = 9'h080, ST_LPMW = 9'h100
   } cdp_state_t;
   typedef enum logic [3:0] {
      OP_SYS = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_AND = 4'h3,
      OP_OR = 4'h4, OP_XOR = 4'h5, OP_MOV = 4'h6, OP_UNARY = 4'h7,
      OP_BIT = 4'h8, OP_IMM = 4'h9, OP_LDST = 4'hA, OP_IO = 4'hB,
      OP_CALL = 4'hC, OP_JMP = 4'hD, OP_RET = 4'hE, OP_LPM = 4'hF
   } cdp_op_t;
   typedef enum logic [3:0] {
      FN_ADD = 4'h0, FN_SUB = 4'h1, FN_AND = 4'h2, FN_OR = 4'h3,
      FN_XOR = 4'h4, FN_MOV = 4'h5, FN_INC = 4'h6, FN_DEC = 4'h7,
      FN_COM = 4'h8, FN_NEG = 4'h9, FN_LSR = 4'hA, FN_ROR = 4'hB,
      FN_SWAP = 4'hC
   } cdp_fn_t;
   typedef enum logic [1:0] {
      RG_REG = 2'h0, RG_IO = 2'h1, RG_SRAM = 2'h2
   } cdp_region_t;
   typedef struct packed {
      logic [7:0] res;
      logic [7:0] sreg;
   } cdp_alu_t;
endpackage

// >>> logic/cdp_core.sv
// Core datapath: register file, ALU, pointers, fetch, stack, interrupts
`timescale 1ns/100ps
`include "cdp_defines.svh"
module cdp_core #(
   parameter int IRQ_NUM = 8,
   parameter logic [15:0] TOP_DATA_ADDR = 16'h015F
) (
   input wire logic core_clk,
   input wire logic nrst,
   output logic [15:0] progAddr_q,
   input wire logic [15:0] progData,
   output logic [15:0] dataAddr_q,
   output logic [7:0] dataWdata_q,
   output logic dataWe_q,
   output logic dataRe_q,
   input wire logic [7:0] dataRdata,
   output logic [5:0] ioAddr_q,
   output logic [7:0] ioWdata_q,
   output logic ioWe_q,
   output logic ioRe_q,
   input wire logic [7:0] ioRdata,
   input wire logic [IRQ_NUM-1:0] irqReq,
   output logic [IRQ_NUM-1:0] irqAck_q
);
   if (IRQ_NUM < 1 || IRQ_NUM > 32) begin : g_bad_irq
      $error("IRQ_NUM must lie in 1..32");
   end

   cdp_pkg::cdp_state_t stateQ;
   logic [7:0] regs [32];
   logic [15:0] irQ;
   logic [15:0] retAddrQ;
   logic [15:0] targetQ;
   logic [15:0] stackPtrQ;
   logic [15:0] zPtr;
   logic [7:0] sregQ;
   logic loadIoQ;
   logic zByteQ;

   logic [15:0] cur;
   cdp_pkg::cdp_op_t op;
   logic [4:0] rd;
   logic [4:0] rr;
   cdp_pkg::cdp_fn_t fn;
   logic [7:0] bOp;
   cdp_pkg::cdp_alu_t alu;
   logic [15:0] pcNext;
   logic [15:0] accAddr;
   cdp_pkg::cdp_region_t accRg;
   logic [5:0] accIoA;
   logic accWr;
   logic isInt;
   logic [7:0] intVal;
   logic goLoad;
   logic irqTake;
   logic [IRQ_NUM-1:0] irqWin;
   logic [15:0] irqVec;
   logic regWe;
   logic [4:0] regWa;
   logic [7:0] regWd;

   function automatic logic [15:0] ptrRead(input logic [1:0] sel);
      logic [4:0] lo;
      lo = 5'h1A + {2'h0, sel, 1'b0};
      return {regs[lo + 5'h01], regs[lo]};
   endfunction

   function automatic cdp_pkg::cdp_region_t region(input logic [15:0] a);
      if (a < `CDP_IO_BASE) return cdp_pkg::RG_REG;
      if (a <= `CDP_IO_LAST) return cdp_pkg::RG_IO;
      return cdp_pkg::RG_SRAM;
   endfunction

   function automatic cdp_pkg::cdp_alu_t aluCompute(input logic [7:0] a, input logic [7:0] b,
                                                    input cdp_pkg::cdp_fn_t f, input logic [7:0] sr);
      logic [8:0] w;
      logic [7:0] r;
      logic [7:0] s;
      w = 9'h000;
      r = 8'h00;
      s = sr;
      unique case (f)
         cdp_pkg::FN_ADD, cdp_pkg::FN_INC: begin
            w = {1'b0, a} + {1'b0, (f == cdp_pkg::FN_INC) ? 8'h01 : b};
            r = w[7:0];
            s[`CDP_F_V] = (a[7] == ((f == cdp_pkg::FN_INC) ? 1'b0 : b[7])) && (r[7] != a[7]);
            if (f == cdp_pkg::FN_ADD) begin
               s[`CDP_F_C] = w[8];
               s[`CDP_F_H] = a[4] ^ b[4] ^ r[4];
            end
         end
         cdp_pkg::FN_SUB, cdp_pkg::FN_DEC, cdp_pkg::FN_NEG: begin
            if (f == cdp_pkg::FN_NEG) w = 9'h000 - {1'b0, a};
            else w = {1'b0, a} - {1'b0, (f == cdp_pkg::FN_DEC) ? 8'h01 : b};
            r = w[7:0];
            s[`CDP_F_V] = (f == cdp_pkg::FN_NEG) ? (r == 8'h80)
                        : (a[7] != ((f == cdp_pkg::FN_DEC) ? 1'b0 : b[7])) && (r[7] != a[7]);
            if (f != cdp_pkg::FN_DEC) begin
               s[`CDP_F_C] = w[8];
               s[`CDP_F_H] = a[4] ^ b[4] ^ r[4];
            end
         end
         cdp_pkg::FN_AND, cdp_pkg::FN_OR, cdp_pkg::FN_XOR: begin
            r = (f == cdp_pkg::FN_AND) ? (a & b) : (f == cdp_pkg::FN_OR) ? (a | b) : (a ^ b);
            s[`CDP_F_V] = 1'b0;
         end
         cdp_pkg::FN_COM: begin
            r = ~a;
            s[`CDP_F_C] = 1'b1;
            s[`CDP_F_V] = 1'b0;
         end
         cdp_pkg::FN_LSR, cdp_pkg::FN_ROR: begin
            r = {(f == cdp_pkg::FN_ROR) & sr[`CDP_F_C], a[7:1]};
            s[`CDP_F_C] = a[0];
            s[`CDP_F_V] = r[7] ^ a[0];
         end
         cdp_pkg::FN_MOV: r = b;
         cdp_pkg::FN_SWAP: r = {a[3:0], a[7:4]};
         default: r = a;
      endcase
      // Moves and swaps leave the flags alone
      if (f != cdp_pkg::FN_MOV && f != cdp_pkg::FN_SWAP) begin
         s[`CDP_F_N] = r[7];
         s[`CDP_F_Z] = (r == 8'h00);
         s[`CDP_F_S] = r[7] ^ s[`CDP_F_V];
      end
      return '{res: r, sreg: s};
   endfunction

   // Word one is live on the fetch bus only in EXEC; later states use the copy
   assign cur = (stateQ == cdp_pkg::ST_EXEC) ? progData : irQ;
   assign op = cdp_pkg::cdp_op_t'(cur[15:12]);
   assign rd = cur[11:7];
   assign rr = cur[6:2];
   assign fn = (op == cdp_pkg::OP_UNARY || op == cdp_pkg::OP_IMM) ? cdp_pkg::cdp_fn_t'(cur[3:0])
             : cdp_pkg::cdp_fn_t'(cur[15:12] - 4'h1);
   assign bOp = (stateQ == cdp_pkg::ST_IMM) ? progData[7:0] : regs[rr];
   assign alu = aluCompute(regs[rd], bOp, fn, sregQ);
   assign pcNext = progAddr_q + 16'h0001;

   always_comb begin
      accAddr = ptrRead(cur[6:5]);
      zPtr = ptrRead(2'h2);
      accWr = cur[4];
      accRg = region(accAddr);
      accIoA = 6'(accAddr - `CDP_IO_BASE);
      if (op == cdp_pkg::OP_IO) begin
         accRg = cdp_pkg::RG_IO;
         accIoA = cur[6:1];
         accWr = cur[0];
      end
      isInt = (accRg == cdp_pkg::RG_IO) && (accIoA >= `CDP_IO_STACK_LOW);
      intVal = (accIoA == `CDP_IO_STACK_LOW) ? stackPtrQ[7:0]
             : (accIoA == `CDP_IO_STACK_HIGH) ? stackPtrQ[15:8] : sregQ;
      goLoad = (op == cdp_pkg::OP_LDST || op == cdp_pkg::OP_IO) && !accWr
               && accRg != cdp_pkg::RG_REG && !isInt;
   end

   // Lowest set request wins; it owns the lowest vector address
   assign irqWin = irqReq & (~irqReq + 1'b1);
   assign irqTake = (stateQ == cdp_pkg::ST_EXEC) && sregQ[`CDP_F_I] && (|irqReq);

   always_comb begin
      irqVec = 16'h0000;
      for (int i = IRQ_NUM - 1; i >= 0; i--) begin
         if (irqReq[i]) irqVec = 16'(i + 1) << `CDP_VEC_SHIFT;
      end
   end

   always_comb begin
      regWe = 1'b0;
      regWa = rd;
      regWd = alu.res;
      unique case (stateQ)
         cdp_pkg::ST_EXEC: begin
            if (!irqTake) begin
               unique case (op)
                  cdp_pkg::OP_ADD, cdp_pkg::OP_SUB, cdp_pkg::OP_AND, cdp_pkg::OP_OR,
                  cdp_pkg::OP_XOR, cdp_pkg::OP_MOV, cdp_pkg::OP_UNARY: regWe = 1'b1;
                  cdp_pkg::OP_BIT: begin
                     regWe = 1'b1;
                     regWd = regs[rd];
                     regWd[cur[2:0]] = cur[3];
                  end
                  cdp_pkg::OP_LDST, cdp_pkg::OP_IO: begin
                     if (accRg == cdp_pkg::RG_REG) begin
                        regWe = 1'b1;
                        regWa = accWr ? accAddr[4:0] : rd;
                        regWd = accWr ? regs[rd] : regs[accAddr[4:0]];
                     end else if (isInt && !accWr) begin
                        regWe = 1'b1;
                        regWd = intVal;
                     end
                  end
                  default: regWe = 1'b0;
               endcase
            end
         end
         cdp_pkg::ST_IMM: regWe = (op == cdp_pkg::OP_IMM);
         cdp_pkg::ST_LOAD: begin
            regWe = 1'b1;
            regWd = loadIoQ ? ioRdata : dataRdata;
         end
         cdp_pkg::ST_LPMW: begin
            regWe = 1'b1;
            regWd = zByteQ ? progData[15:8] : progData[7:0];
         end
         default: regWe = 1'b0;
      endcase
   end

   // Register file is data, not control, so it has no reset
   always_ff @(posedge core_clk) begin
      if (regWe) regs[regWa] <= regWd;
   end

   // Every state advances on each core_clk edge, no divider
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stateQ <= cdp_pkg::ST_EXEC;
      end else begin
         unique case (stateQ)
            cdp_pkg::ST_EXEC: begin
               if (irqTake) stateQ <= cdp_pkg::ST_PUSH1;
               else if (op == cdp_pkg::OP_IMM || op == cdp_pkg::OP_CALL || op == cdp_pkg::OP_JMP)
                  stateQ <= cdp_pkg::ST_IMM;
               else if (op == cdp_pkg::OP_RET) stateQ <= cdp_pkg::ST_POP1;
               else if (op == cdp_pkg::OP_LPM) stateQ <= cdp_pkg::ST_LPMW;
               else if (goLoad) stateQ <= cdp_pkg::ST_LOAD;
            end
            cdp_pkg::ST_IMM: stateQ <= (op == cdp_pkg::OP_CALL) ? cdp_pkg::ST_PUSH1 : cdp_pkg::ST_EXEC;
            cdp_pkg::ST_PUSH1: stateQ <= cdp_pkg::ST_PUSH2;
            cdp_pkg::ST_POP1: stateQ <= cdp_pkg::ST_POP2;
            cdp_pkg::ST_POP2: stateQ <= cdp_pkg::ST_POP3;
            default: stateQ <= cdp_pkg::ST_EXEC;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         progAddr_q <= 16'h0000;
      end else begin
         unique case (stateQ)
            cdp_pkg::ST_EXEC: begin
               if (!irqTake && op == cdp_pkg::OP_LPM) progAddr_q <= {1'b0, zPtr[15:1]};
               else if (!irqTake && op != cdp_pkg::OP_RET && !goLoad) progAddr_q <= pcNext;
            end
            cdp_pkg::ST_IMM: begin
               if (op == cdp_pkg::OP_JMP) progAddr_q <= progData;
               else if (op != cdp_pkg::OP_CALL) progAddr_q <= pcNext;
            end
            cdp_pkg::ST_LOAD: progAddr_q <= pcNext;
            cdp_pkg::ST_LPMW: progAddr_q <= retAddrQ;
            cdp_pkg::ST_PUSH2: progAddr_q <= targetQ;
            cdp_pkg::ST_POP3: progAddr_q <= {retAddrQ[15:8], dataRdata};
            default: progAddr_q <= progAddr_q;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irQ <= 16'h0000;
         retAddrQ <= 16'h0000;
         targetQ <= 16'h0000;
         zByteQ <= 1'b0;
         loadIoQ <= 1'b0;
      end else begin
         if (stateQ == cdp_pkg::ST_EXEC) begin
            irQ <= progData;
            loadIoQ <= (accRg == cdp_pkg::RG_IO);
            zByteQ <= zPtr[0];
            if (irqTake) begin
               retAddrQ <= progAddr_q;
               targetQ <= irqVec;
            end else if (op == cdp_pkg::OP_LPM) begin
               retAddrQ <= pcNext;
            end
         end
         if (stateQ == cdp_pkg::ST_IMM && op == cdp_pkg::OP_CALL) begin
            retAddrQ <= pcNext;
            targetQ <= progData;
         end
         if (stateQ == cdp_pkg::ST_POP2) retAddrQ[15:8] <= dataRdata;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stackPtrQ <= TOP_DATA_ADDR;
      end else if (stateQ == cdp_pkg::ST_PUSH1 || stateQ == cdp_pkg::ST_PUSH2) begin
         stackPtrQ <= stackPtrQ - 16'h0001;
      end else if (stateQ == cdp_pkg::ST_POP1 || stateQ == cdp_pkg::ST_POP2) begin
         stackPtrQ <= stackPtrQ + 16'h0001;
      end else if (stateQ == cdp_pkg::ST_EXEC && !irqTake && isInt && accWr) begin
         if (accIoA == `CDP_IO_STACK_LOW) stackPtrQ[7:0] <= regs[rd];
         if (accIoA == `CDP_IO_STACK_HIGH) stackPtrQ[15:8] <= regs[rd];
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sregQ <= `CDP_SREG_RESET;
      end else if (irqTake) begin
         sregQ[`CDP_F_I] <= 1'b0;
      end else if (stateQ == cdp_pkg::ST_EXEC) begin
         if (op inside {cdp_pkg::OP_ADD, cdp_pkg::OP_SUB, cdp_pkg::OP_AND, cdp_pkg::OP_OR,
                        cdp_pkg::OP_XOR, cdp_pkg::OP_UNARY}) sregQ <= alu.sreg;
         else if (op == cdp_pkg::OP_SYS && cur[1:0] != 2'h0) sregQ[`CDP_F_I] <= (cur[1:0] == 2'h1);
         else if (isInt && accWr && accIoA == `CDP_IO_SREG) sregQ <= regs[rd];
      end else if (stateQ == cdp_pkg::ST_IMM && op == cdp_pkg::OP_IMM) begin
         sregQ <= alu.sreg;
      end else if (stateQ == cdp_pkg::ST_POP3 && cur[0]) begin
         sregQ[`CDP_F_I] <= 1'b1;
      end
   end

   // Stack writes land one cycle after the state that orders them
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dataAddr_q <= 16'h0000;
         dataWdata_q <= 8'h00;
         dataWe_q <= 1'b0;
         dataRe_q <= 1'b0;
      end else begin
         dataWe_q <= 1'b0;
         dataRe_q <= 1'b0;
         if (stateQ == cdp_pkg::ST_EXEC && !irqTake && op == cdp_pkg::OP_LDST
             && accRg == cdp_pkg::RG_SRAM) begin
            dataAddr_q <= accAddr;
            dataWdata_q <= regs[rd];
            dataWe_q <= accWr;
            dataRe_q <= !accWr;
         end else if (stateQ == cdp_pkg::ST_PUSH1 || stateQ == cdp_pkg::ST_PUSH2) begin
            dataAddr_q <= stackPtrQ;
            dataWdata_q <= (stateQ == cdp_pkg::ST_PUSH1) ? retAddrQ[7:0] : retAddrQ[15:8];
            dataWe_q <= 1'b1;
         end else if (stateQ == cdp_pkg::ST_POP1 || stateQ == cdp_pkg::ST_POP2) begin
            dataAddr_q <= stackPtrQ + 16'h0001;
            dataRe_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ioAddr_q <= 6'h00;
         ioWdata_q <= 8'h00;
         ioWe_q <= 1'b0;
         ioRe_q <= 1'b0;
      end else begin
         ioWe_q <= 1'b0;
         ioRe_q <= 1'b0;
         if (stateQ == cdp_pkg::ST_EXEC && !irqTake && (op == cdp_pkg::OP_LDST || op == cdp_pkg::OP_IO)
             && accRg == cdp_pkg::RG_IO && !isInt) begin
            ioAddr_q <= accIoA;
            ioWdata_q <= regs[rd];
            ioWe_q <= accWr;
            ioRe_q <= !accWr;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) irqAck_q <= '0;
      else irqAck_q <= irqTake ? irqWin : '0;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence sPushRet;
      (dataWe_q && dataWdata_q == retAddrQ[7:0]) ##1 (dataWe_q && dataWdata_q == retAddrQ[15:8]);
   endsequence
   sequence sExecOp(cdp_pkg::cdp_op_t o);
      stateQ == cdp_pkg::ST_EXEC && !irqTake && op == o;
   endsequence

   chk_call_push: assert property ((stateQ == cdp_pkg::ST_IMM && op == cdp_pkg::OP_CALL)
      |-> ##2 sPushRet ##0 (progAddr_q == targetQ)) else $error("call push wrong");
   chk_sp_reset: assert property ($rose(nrst) |-> stackPtrQ == TOP_DATA_ADDR)
      else $error("stack pointer reset wrong");
   chk_push_dec: assert property ((stateQ == cdp_pkg::ST_PUSH1)
      |=> (stackPtrQ == $past(stackPtrQ) - 16'h0001) ##1 (stackPtrQ == $past(stackPtrQ, 2) - 16'h0002))
      else $error("push does not decrement");
   chk_alu_cycle: assert property (sExecOp(cdp_pkg::OP_ADD)
      |=> regs[$past(rd)] == $past(regs[rd] + regs[rr]) && progAddr_q == $past(pcNext))
      else $error("single cycle add wrong");
   chk_zero_flag: assert property (sExecOp(cdp_pkg::OP_SUB)
      |=> sregQ[`CDP_F_Z] == ($past(regs[rd]) == $past(regs[rr])))
      else $error("zero flag wrong");
   chk_irq_prio: assert property (irqAck_q != '0
      |-> $onehot(irqAck_q) && ($past(irqReq) & (irqAck_q - 1'b1)) == '0 && (irqAck_q & $past(irqReq)) != '0)
      else $error("interrupt priority wrong");
   chk_gie_gate: assert property ((stateQ == cdp_pkg::ST_EXEC && !sregQ[`CDP_F_I]) |=> irqAck_q == '0)
      else $error("interrupt taken while disabled");
   chk_io_window: assert property ((sExecOp(cdp_pkg::OP_LDST) ##0 (accRg == cdp_pkg::RG_IO && !isInt))
      |=> (ioWe_q || ioRe_q) && ioAddr_q == 6'($past(accAddr) - 16'h0020))
      else $error("io window mapping wrong");
   chk_two_word: assert property (sExecOp(cdp_pkg::OP_JMP)
      |=> stateQ == cdp_pkg::ST_IMM ##1 progAddr_q == $past(progData))
      else $error("two word jump wrong");
endmodule // cdp_core

// >>> sim/cdp_mem_model.sv
// Program memory, data SRAM and I/O registers on the far side of the core
`timescale 1ns/100ps
module cdp_mem_model (
   input wire logic core_clk,
   input wire logic [15:0] progAddr,
   output logic [15:0] progData,
   input wire logic [15:0] dataAddr,
   input wire logic [7:0] dataWdata,
   input wire logic dataWe,
   input wire logic dataRe,
   output logic [7:0] dataRdata,
   input wire logic [5:0] ioAddr,
   input wire logic [7:0] ioWdata,
   input wire logic ioWe,
   input wire logic ioRe,
   output logic [7:0] ioRdata
);
   logic [15:0] rom [0:255];
   logic [7:0] sram [0:511];
   logic [7:0] io [0:63];
   logic [23:0] wlog [$];
   logic [7:0] dLast = 8'h00;
   logic [7:0] iLast = 8'h00;
   initial begin
      for (int i = 0; i < 512; i++) sram[i] = 8'h00;
      for (int i = 0; i < 64; i++) io[i] = 8'h00;
   end
   assign progData = rom[progAddr[7:0]];
   // Write log keeps order, so stack byte order is visible to the bench
   always @(posedge core_clk) begin
      if (dataWe) begin
         sram[dataAddr[8:0]] <= dataWdata;
         wlog.push_back({dataAddr, dataWdata});
      end
      if (ioWe) io[ioAddr] <= ioWdata;
   end
   // Core takes read data in the strobe's own cycle; idle lines show the
   // inverse of the last byte so stale data never matches
   assign dataRdata = dataRe ? sram[dataAddr[8:0]] : ~dLast;
   assign ioRdata = ioRe ? io[ioAddr] : ~iLast;
   always @(posedge core_clk) begin
      if (dataRe) dLast <= sram[dataAddr[8:0]];
      if (ioRe) iLast <= io[ioAddr];
   end
endmodule // cdp_mem_model

// >>> sim/tb_cdp_core_datapath_stack.sv
// Self-checking bench: program built in memory, results read from the write log
`timescale 1ns/100ps
module tb_cdp_core_datapath_stack;
   localparam logic [15:0] TOP = 16'h015F;
   localparam logic [15:0] SUBA = 16'h00C0;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] irqReq = 8'h00;
   logic [15:0] progAddr_q, progData, dataAddr_q;
   logic [7:0] dataWdata_q, dataRdata, ioWdata_q, ioRdata, irqAck_q, ack;
   logic dataWe_q, dataRe_q, ioWe_q, ioRe_q, found;
   logic [5:0] ioAddr_q;
   logic [15:0] pa, ret, loopAt;
   logic [23:0] exp [0:14];
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;

   cdp_core #(.IRQ_NUM(8), .TOP_DATA_ADDR(TOP)) dut_u (.core_clk(core_clk), .nrst(nrst),
      .progAddr_q(progAddr_q), .progData(progData), .dataAddr_q(dataAddr_q), .dataWdata_q(dataWdata_q),
      .dataWe_q(dataWe_q), .dataRe_q(dataRe_q), .dataRdata(dataRdata), .ioAddr_q(ioAddr_q),
      .ioWdata_q(ioWdata_q), .ioWe_q(ioWe_q), .ioRe_q(ioRe_q), .ioRdata(ioRdata), .irqReq(irqReq),
      .irqAck_q(irqAck_q));
   cdp_mem_model mdl_u (.core_clk(core_clk), .progAddr(progAddr_q), .progData(progData),
      .dataAddr(dataAddr_q), .dataWdata(dataWdata_q), .dataWe(dataWe_q), .dataRe(dataRe_q),
      .dataRdata(dataRdata), .ioAddr(ioAddr_q), .ioWdata(ioWdata_q), .ioWe(ioWe_q), .ioRe(ioRe_q),
      .ioRdata(ioRdata));

   always #25 core_clk = ~core_clk;

   function automatic logic [15:0] w(input logic [3:0] op, input logic [4:0] rd, input logic [6:0] lo);
      return {op, rd, lo};
   endfunction
   task automatic put(input logic [15:0] v);
      mdl_u.rom[pa[7:0]] = v;
      pa = pa + 16'h0001;
   endtask
   task automatic imm(input logic [3:0] fn, input logic [4:0] rd, input logic [7:0] v);
      put(w(4'h9, rd, {3'h0, fn}));
      put({8'h00, v});
   endtask
   // Store through X, then step X so every result lands at its own byte
   task automatic stx(input logic [4:0] rd);
      put(w(4'hA, rd, 7'h10));
      imm(4'h0, 5'h1A, 8'h01);
   endtask
   task automatic io_op(input logic [4:0] rd, input logic [5:0] a, input logic wr);
      put(w(4'hB, rd, {a, wr}));
   endtask
   task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wait_ack(output logic [7:0] a);
      a = 8'h00;
      for (int i = 0; i < 400 && a === 8'h00; i++) begin
         @(posedge core_clk);
         #2;
         a = irqAck_q;
      end
   endtask
   task automatic wait_pc(input logic [15:0] t, output logic f);
      f = 1'b0;
      for (int i = 0; i < 8 && !f; i++) begin
         @(posedge core_clk);
         #2;
         f = (progAddr_q === t);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         close_out();
      end
   end

   initial begin
      for (int i = 0; i < 256; i++) mdl_u.rom[i] = 16'h0000;
      for (int k = 0; k < 8; k++) mdl_u.rom[(k + 1) * 2] = 16'hE001;
      mdl_u.rom[0] = 16'hD000;
      mdl_u.rom[1] = 16'h0020;
      pa = 16'h0020;
      io_op(5'h14, 6'h3D, 1'b0);
      io_op(5'h15, 6'h3E, 1'b0);
      imm(4'h5, 5'h1A, 8'h00);
      imm(4'h5, 5'h1B, 8'h01);
      stx(5'h14);
      stx(5'h15);
      // Stack moved before any call or interrupt
      imm(4'h5, 5'h14, 8'h50);
      io_op(5'h14, 6'h3D, 1'b1);
      imm(4'h5, 5'h15, 8'h01);
      io_op(5'h15, 6'h3E, 1'b1);
      imm(4'h5, 5'h10, 8'h0F);
      imm(4'h5, 5'h11, 8'h01);
      put(w(4'h1, 5'h10, 7'h44));
      io_op(5'h16, 6'h3F, 1'b0);
      stx(5'h10);
      stx(5'h16);
      imm(4'h5, 5'h13, 8'h00);
      put(w(4'h2, 5'h13, 7'h44));
      io_op(5'h16, 6'h3F, 1'b0);
      stx(5'h13);
      stx(5'h16);
      imm(4'h5, 5'h1C, 8'h25);
      imm(4'h5, 5'h1D, 8'h00);
      put(w(4'hA, 5'h10, 7'h30));
      put(w(4'hA, 5'h17, 7'h20));
      stx(5'h17);
      imm(4'h5, 5'h1E, 8'h41);
      imm(4'h5, 5'h1F, 8'h00);
      put(w(4'hF, 5'h18, 7'h00));
      stx(5'h18);
      put(16'hC000);
      put(SUBA);
      ret = pa;
      stx(5'h19);
      put(16'h0001);
      loopAt = pa;
      put(16'hD000);
      put(loopAt);
      pa = SUBA;
      imm(4'h5, 5'h19, 8'hA5);
      put(16'hE000);
      exp[0] = {16'h0100, TOP[7:0]};
      exp[1] = {16'h0101, TOP[15:8]};
      exp[2] = 24'h010210;
      exp[3] = 24'h010320;
      exp[4] = 24'h0104FF;
      exp[5] = 24'h010535;
      exp[6] = 24'h010610;
      exp[7] = {16'h0107, mdl_u.rom[8'h20][15:8]};
      exp[8] = {16'h0150, ret[7:0]};
      exp[9] = {16'h014F, ret[15:8]};
      exp[10] = 24'h0108A5;
      for (int k = 0; k < 4; k++) exp[11 + k] = k[0] ? {16'h014F, loopAt[15:8]} : {16'h0150, loopAt[7:0]};
      repeat (4) @(posedge core_clk);
      #2;
      chk("reset progAddr", 24'h000000, {8'h00, progAddr_q});
      chk("reset strobes", 24'h000000, {8'h00, irqAck_q, 4'h0, dataWe_q, dataRe_q, ioWe_q, ioRe_q});
      $display("test reset done");
      nrst = 1'b1;
      // Requests pending from the start stay refused until I is set
      irqReq = 8'h0A;
      wait_ack(ack);
      chk("first ack", 24'h000002, {16'h0000, ack});
      chk("writes before ack", 24'd11, 24'(mdl_u.wlog.size()));
      irqReq = irqReq & ~ack;
      wait_pc(16'h0004, found);
      chk("vector 1", 24'h000001, {23'h0, found});
      wait_ack(ack);
      chk("second ack", 24'h000008, {16'h0000, ack});
      irqReq = irqReq & ~ack;
      wait_pc(16'h0008, found);
      chk("vector 3", 24'h000001, {23'h0, found});
      $display("test interrupts done");
      repeat (30) @(posedge core_clk);
      #2;
      chk("write count", 24'd15, 24'(mdl_u.wlog.size()));
      for (int k = 0; k < 15 && k < mdl_u.wlog.size(); k++) begin
         chk("data write", exp[k], mdl_u.wlog[k]);
      end
      chk("io mirror byte", 24'h000010, {16'h0000, mdl_u.io[5]});
      $display("test datapath done");
      close_out();
   end
endmodule // tb_cdp_core_datapath_stack
